// ==== logic/l2_dirty_sync_consts.vh ====
/*
 Constants for the dirty-state, eviction and sync block: widths,
 reset values, latency codes and way-size codes.
 Assumes inclusion by its bare name from the design file.
*/
`ifndef L2_DIRTY_SYNC_CONSTS_VH
`define L2_DIRTY_SYNC_CONSTS_VH

// Dirty word: two bits per way, eight ways.
`define DIRTY_W 16
// Index width shared with the tag RAM address bus.
`define IDX_W 13
// Dirty RAM depth at the largest way size.
`define DIRTY_DEPTH 8192
// Latency code is latency minus one; reset is the slowest, eight.
`define LAT_W 3
`define LAT_RESET 3'h7
// Way count field, one to eight ways.
`define WAYS_W 4
`define WAYS_RESET 4'h8
// Way size codes: 16KB, 32KB, 64KB, 128KB, 256KB.
`define WSZ_16K 3'h0
`define WSZ_32K 3'h1
`define WSZ_64K 3'h2
`define WSZ_128K 3'h3
`define WSZ_256K 3'h4
// Eviction buffer: one line of eight words or two halves of four.
`define LINE_WORDS 4'h8
`define HALF_WORDS 4'h4
`define WORD_W 32
`define CNT_W 4

`endif

// ==== logic/l2_dirty_sync_master_port.v ====
/*
 Dirty-state RAM with programmable latency, eviction buffer drained
 by bursts to master port 0, sync sequencing and linefill tracking.
 Assumes the master clock arrives as a plain pin sampled by clk, and
 that latency and size are changed only while the cache is disabled.
*/
`timescale 1ns/100ps
`default_nettype none
`include "l2_dirty_sync_consts.vh"

module l2_dirty_sync_master_port #(
	// Zero removes the asynchronous crossing; the strap is then ignored.
	parameter ASYNC_PRESENT = 1
) (
	// Clock and core reset.
	input wire clk,
	input wire reset_n,
	// Configuration.
	input wire cache_enable,
	input wire [`WAYS_W-1:0] way_count,
	input wire [2:0] way_size_sel,
	input wire [`LAT_W-1:0] ram_latency,
	// Dirty RAM access.
	input wire dirty_req,
	input wire dirty_write,
	input wire [`IDX_W-1:0] dirty_index,
	input wire [2:0] dirty_way,
	input wire [1:0] dirty_half_mask,
	input wire dirty_value,
	output reg dirty_ready_reg,
	output reg dirty_rvalid_reg,
	output reg [`DIRTY_W-1:0] dirty_rdata_reg,
	// Eviction buffer fill.
	input wire evict_push,
	input wire [`WORD_W-1:0] evict_word,
	output reg evict_ready_reg,
	// Linefill tracking per master port.
	input wire [1:0] linefill_start,
	input wire [1:0] linefill_done,
	output reg [1:0] linefill_busy_reg,
	// Sync and maintenance.
	input wire sync_req,
	input wire maint_req,
	input wire write_buffer_empty,
	input wire write_alloc_empty,
	output reg sync_busy_reg,
	output reg sync_done_reg,
	output reg maint_go_reg,
	// Master port 0 write burst and its link pins.
	input wire sync_mode_select,
	input wire master_clock,
	input wire master_clock_enable,
	input wire master_bus_reset_n,
	output reg master_port_0_valid_reg,
	output reg master_port_0_first_reg,
	output reg master_port_0_last_reg,
	output reg [`WORD_W-1:0] master_port_0_wdata_reg
);

////////////////////////////////////////////////////////////////////////
// Pin sampling of the master clock, its enable and its reset.

// Three-stage samplers, one per pin.
wire [2:0] pin_in;
reg [2:0] pin_s1_reg;
reg [2:0] pin_s2_reg;
reg [2:0] pin_s3_reg;
// Last accepted level of each pin.
reg [2:0] pin_lvl_reg;

assign pin_in = {master_bus_reset_n, master_clock_enable, master_clock};

genvar gi;
generate
	for (gi = 0; gi < 3; gi = gi + 1) begin : pin_sample
		// A change counts once the second and third stages agree.
		always @(posedge clk or negedge reset_n) begin
			if (!reset_n) begin
				pin_s1_reg[gi] <= 1'b0;
				pin_s2_reg[gi] <= 1'b0;
				pin_s3_reg[gi] <= 1'b0;
				pin_lvl_reg[gi] <= 1'b0;
			end else begin
				pin_s1_reg[gi] <= pin_in[gi];
				pin_s2_reg[gi] <= pin_s1_reg[gi];
				pin_s3_reg[gi] <= pin_s2_reg[gi];
				if (pin_s2_reg[gi] == pin_s3_reg[gi]) begin
					pin_lvl_reg[gi] <= pin_s3_reg[gi];
				end
			end
		end
	end
endgenerate

// Rising edge of the sampled master clock.
wire mclk_rise;
assign mclk_rise = (pin_s2_reg[0] == pin_s3_reg[0]) && pin_s3_reg[0] &&
	!pin_lvl_reg[0];

// Asynchronous crossing in use only when built and the strap is low.
wire async_mode;
assign async_mode = (ASYNC_PRESENT != 0) && !sync_mode_select;

// One master beat may advance on this cycle.
// In synchronous mode the enable is used directly, adding no delay.
wire master_step;
assign master_step = async_mode ?
	(mclk_rise && pin_lvl_reg[1]) :
	master_clock_enable;

// Master side held in reset.
wire master_rst;
assign master_rst = async_mode ? !pin_lvl_reg[2] : !master_bus_reset_n;

////////////////////////////////////////////////////////////////////////
// Configuration capture.

// Latency and size are only taken while the cache is disabled.
reg [`LAT_W-1:0] lat_reg;
reg [`WAYS_W-1:0] ways_reg;
reg [2:0] wsz_reg;

// Loads settings while disabled; holds them once enabled.
always @(posedge clk or negedge reset_n) begin
	if (!reset_n) begin
		lat_reg <= `LAT_RESET;
		ways_reg <= `WAYS_RESET;
		wsz_reg <= `WSZ_256K;
	end else if (!cache_enable) begin
		lat_reg <= ram_latency;
		ways_reg <= way_count;
		wsz_reg <= way_size_sel;
	end
end

// Index bits in use for the selected way size.
reg [`IDX_W-1:0] idx_mask;

// Clears unconnected upper index bits.
always @* begin
	case (wsz_reg)
		`WSZ_16K: idx_mask = 13'h01FF;
		`WSZ_32K: idx_mask = 13'h03FF;
		`WSZ_64K: idx_mask = 13'h07FF;
		`WSZ_128K: idx_mask = 13'h0FFF;
		default: idx_mask = 13'h1FFF;
	endcase
end

// Dirty bits of ways present; absent ways read as zero.
reg [`DIRTY_W-1:0] way_mask;
integer wi;

// Two bits enabled per configured way.
always @* begin
	way_mask = 16'h0000;
	for (wi = 0; wi < 8; wi = wi + 1) begin
		if (wi < ways_reg) begin
			way_mask[2*wi] = 1'b1;
			way_mask[2*wi+1] = 1'b1;
		end
	end
end

////////////////////////////////////////////////////////////////////////
// Dirty RAM with programmable access latency.

// Dirty storage, one word per index.
reg [`DIRTY_W-1:0] dirty_mem [0:`DIRTY_DEPTH-1];
// Captured request.
reg [`IDX_W-1:0] acc_idx_reg;
reg acc_wr_reg;
reg [2:0] acc_way_reg;
reg [1:0] acc_half_reg;
reg acc_val_reg;
// Cycles left in the current access.
reg [`LAT_W-1:0] acc_cnt_reg;
reg acc_busy_reg;

// Request accepted this cycle.
wire acc_take;
assign acc_take = dirty_req && dirty_ready_reg;

// Access finishes on this cycle.
wire acc_end;
assign acc_end = acc_busy_reg && (acc_cnt_reg == 3'h0);

// Captures a request, then counts the latency down to the sample edge.
always @(posedge clk or negedge reset_n) begin
	if (!reset_n) begin
		acc_idx_reg <= 13'h0000;
		acc_wr_reg <= 1'b0;
		acc_way_reg <= 3'h0;
		acc_half_reg <= 2'h0;
		acc_val_reg <= 1'b0;
		acc_cnt_reg <= 3'h0;
		acc_busy_reg <= 1'b0;
	end else if (acc_take) begin
		// Same index as the tag RAM address bus.
		acc_idx_reg <= dirty_index & idx_mask;
		acc_wr_reg <= dirty_write;
		acc_way_reg <= dirty_way;
		acc_half_reg <= dirty_half_mask;
		acc_val_reg <= dirty_value;
		acc_cnt_reg <= lat_reg;
		acc_busy_reg <= 1'b1;
	end else if (acc_end) begin
		acc_busy_reg <= 1'b0;
	end else if (acc_busy_reg) begin
		acc_cnt_reg <= acc_cnt_reg - 3'h1;
	end
end

// Ready whenever no access runs; linefills never block it.
always @(posedge clk or negedge reset_n) begin
	if (!reset_n) begin
		dirty_ready_reg <= 1'b0;
	end else begin
		dirty_ready_reg <= !(acc_take || (acc_busy_reg && !acc_end));
	end
end

// Per-bit write: only the chosen halves of one way change.
always @(posedge clk) begin
	if (acc_end && acc_wr_reg) begin
		if (acc_half_reg[0]) begin
			dirty_mem[acc_idx_reg][{acc_way_reg, 1'b0}] <= acc_val_reg;
		end
		if (acc_half_reg[1]) begin
			dirty_mem[acc_idx_reg][{acc_way_reg, 1'b1}] <= acc_val_reg;
		end
	end
end

// Full-word read sampled at the end of the latency.
always @(posedge clk or negedge reset_n) begin
	if (!reset_n) begin
		dirty_rvalid_reg <= 1'b0;
		dirty_rdata_reg <= 16'h0000;
	end else begin
		dirty_rvalid_reg <= acc_end && !acc_wr_reg;
		if (acc_end && !acc_wr_reg) begin
			dirty_rdata_reg <= dirty_mem[acc_idx_reg] & way_mask;
		end
	end
end

////////////////////////////////////////////////////////////////////////
// Linefill buffers, one per master port 0 and 1.

// Outstanding flag per port; a start wins over a done.
always @(posedge clk or negedge reset_n) begin
	if (!reset_n) begin
		linefill_busy_reg <= 2'h0;
	end else begin
		linefill_busy_reg <= (linefill_busy_reg & ~linefill_done) |
			linefill_start;
	end
end

////////////////////////////////////////////////////////////////////////
// Eviction buffer and its burst to master port 0.

localparam E_FILL = 2'h1;
localparam E_BURST = 2'h2;

// Buffered words of one line or two half lines.
reg [`WORD_W-1:0] evict_mem [0:7];
reg [`CNT_W-1:0] wr_cnt_reg;
reg [`CNT_W-1:0] rd_ptr_reg;
reg [1:0] e_state_reg;
// Flush request from the sync sequencer.
wire sync_flush;

// Word taken into the buffer this cycle.
wire evict_take;
assign evict_take = evict_push && evict_ready_reg;

// Stores pushed words while filling.
always @(posedge clk) begin
	if (evict_take) begin
		evict_mem[wr_cnt_reg[2:0]] <= evict_word;
	end
end

// Buffer empty and the bus idle.
wire evict_empty;
assign evict_empty = e_state_reg == E_FILL && wr_cnt_reg == 4'h0 &&
	!master_port_0_valid_reg;

// Fills to a line, or to whatever is held on a flush, then bursts it out.
always @(posedge clk or negedge reset_n) begin
	if (!reset_n) begin
		e_state_reg <= E_FILL;
		wr_cnt_reg <= 4'h0;
		rd_ptr_reg <= 4'h0;
	end else begin
		case (e_state_reg)
			E_FILL: begin
				// Fill words; a flush sends what is held.
				if (evict_take) begin
					wr_cnt_reg <= wr_cnt_reg + 4'h1;
				end else if (wr_cnt_reg == `LINE_WORDS ||
					(sync_flush && wr_cnt_reg != 4'h0)) begin
					rd_ptr_reg <= 4'h0;
					e_state_reg <= E_BURST;
				end
			end
			E_BURST: begin
				// One beat per master step; reset abandons it.
				if (master_rst) begin
					wr_cnt_reg <= 4'h0;
					e_state_reg <= E_FILL;
				end else if (master_step) begin
					if (rd_ptr_reg == wr_cnt_reg - 4'h1) begin
						wr_cnt_reg <= 4'h0;
						e_state_reg <= E_FILL;
					end
					rd_ptr_reg <= rd_ptr_reg + 4'h1;
				end
			end
			default: begin
				e_state_reg <= E_FILL;
			end
		endcase
	end
end

// Ready while filling and not full, except at a half line while a sync flush runs.
always @(posedge clk or negedge reset_n) begin
	if (!reset_n) begin
		evict_ready_reg <= 1'b0;
	end else begin
		evict_ready_reg <= e_state_reg == E_FILL &&
			(wr_cnt_reg + (evict_take ? 4'h1 : 4'h0)) < `LINE_WORDS &&
			!(wr_cnt_reg == `HALF_WORDS && sync_flush);
	end
end

// Burst beats presented on each master step.
always @(posedge clk or negedge reset_n) begin
	if (!reset_n) begin
		master_port_0_valid_reg <= 1'b0;
		master_port_0_first_reg <= 1'b0;
		master_port_0_last_reg <= 1'b0;
		master_port_0_wdata_reg <= 32'h00000000;
	end else if (master_rst) begin
		master_port_0_valid_reg <= 1'b0;
		master_port_0_first_reg <= 1'b0;
		master_port_0_last_reg <= 1'b0;
	end else if (master_step) begin
		master_port_0_valid_reg <= e_state_reg == E_BURST;
		master_port_0_first_reg <= e_state_reg == E_BURST &&
			rd_ptr_reg == 4'h0;
		master_port_0_last_reg <= e_state_reg == E_BURST &&
			rd_ptr_reg == wr_cnt_reg - 4'h1;
		master_port_0_wdata_reg <= evict_mem[rd_ptr_reg[2:0]];
	end
end

////////////////////////////////////////////////////////////////////////
// Sync sequencer.

localparam S_IDLE = 2'h1;
localparam S_DRAIN = 2'h2;

reg [1:0] s_state_reg;
// A maintenance operation waits for this sync.
reg maint_pend_reg;

assign sync_flush = s_state_reg == S_DRAIN;

// All buffers empty; linefills are not looked at.
wire bufs_empty;
assign bufs_empty = evict_empty && write_buffer_empty &&
	write_alloc_empty;

// Drains on a sync or maintenance request and reports completion.
always @(posedge clk or negedge reset_n) begin
	if (!reset_n) begin
		s_state_reg <= S_IDLE;
		maint_pend_reg <= 1'b0;
		sync_busy_reg <= 1'b0;
		sync_done_reg <= 1'b0;
		maint_go_reg <= 1'b0;
	end else begin
		sync_done_reg <= 1'b0;
		maint_go_reg <= 1'b0;
		case (s_state_reg)
			S_IDLE: begin
				// Maintenance always starts with a sync.
				if (sync_req || maint_req) begin
					maint_pend_reg <= maint_req;
					sync_busy_reg <= 1'b1;
					s_state_reg <= S_DRAIN;
				end
			end
			S_DRAIN: begin
				// A late maintenance request joins this sync.
				if (maint_req) begin
					maint_pend_reg <= 1'b1;
				end
				if (bufs_empty) begin
					sync_done_reg <= 1'b1;
					maint_go_reg <= maint_pend_reg || maint_req;
					maint_pend_reg <= 1'b0;
					sync_busy_reg <= 1'b0;
					s_state_reg <= S_IDLE;
				end
			end
			default: begin
				s_state_reg <= S_IDLE;
			end
		endcase
	end
end

endmodule
`default_nettype wire

// ==== tb/l2_dirty_sync_sva.sv ====
/*
 Checker for the dirty-state, eviction and sync block.
 Assumes a bind from the bench top; one clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
module l2_dirty_sync_sva (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset_n,
	// Dirty RAM side.
	input wire logic [2:0] ram_latency,
	input wire logic dirty_req,
	input wire logic dirty_write,
	input wire logic dirty_ready_reg,
	input wire logic dirty_rvalid_reg,
	// Sync side.
	input wire logic sync_req,
	input wire logic maint_req,
	input wire logic write_buffer_empty,
	input wire logic write_alloc_empty,
	input wire logic sync_busy_reg,
	input wire logic sync_done_reg,
	input wire logic maint_go_reg,
	// Master port side.
	input wire logic evict_ready_reg,
	input wire logic sync_mode_select,
	input wire logic master_port_0_valid_reg,
	input wire logic master_port_0_first_reg,
	input wire logic master_port_0_last_reg
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	// A read taken this edge.
	wire logic take_rd = dirty_req && dirty_ready_reg && !dirty_write;
	chk_lat_eight: assert property (take_rd && ram_latency == 3'h7 &&
		$past(ram_latency) == 3'h7 |-> ##9 dirty_rvalid_reg)
		else $error("read at latency eight late or early");
	chk_lat_one: assert property (take_rd && ram_latency == 3'h0 &&
		$past(ram_latency) == 3'h0 |-> ##2 dirty_rvalid_reg)
		else $error("read at latency one late or early");
	chk_rvalid_pulse: assert property (dirty_rvalid_reg |=>
		!dirty_rvalid_reg) else $error("read valid longer than a cycle");
	chk_done_empty: assert property (sync_done_reg |->
		$past(write_buffer_empty && write_alloc_empty))
		else $error("sync done with buffers not empty");
	chk_done_pulse: assert property (sync_done_reg |=>
		!sync_done_reg) else $error("sync done longer than a cycle");
	chk_sync_starts: assert property (sync_req && !sync_busy_reg |=>
		sync_busy_reg || sync_done_reg) else $error("sync not started");
	chk_maint_pair: assert property (maint_go_reg |->
		sync_done_reg) else $error("maintenance without sync done");
	chk_maint_runs: assert property (maint_req && !sync_busy_reg &&
		write_buffer_empty && write_alloc_empty |-> ##[1:40] maint_go_reg)
		else $error("maintenance never started");
	chk_burst_busy: assert property (master_port_0_valid_reg &&
		!master_port_0_last_reg |-> !evict_ready_reg)
		else $error("push accepted during burst");
	chk_first_valid: assert property (master_port_0_first_reg |->
		master_port_0_valid_reg) else $error("first beat without valid");
	chk_sync_eight: assert property ($rose(master_port_0_first_reg) &&
		sync_mode_select && !sync_busy_reg |->
		##7 master_port_0_last_reg)
		else $error("synchronous line burst not eight beats");
endmodule
`default_nettype wire

// ==== tb/master_port_far_end.sv ====
/*
 Far end of master port 0: free-running bus clock, enable, reset,
 and a collector of burst beats. Assumes distinct words per beat.
*/
`timescale 1ns/100ps
`default_nettype none
module master_port_far_end (
	// Core clock and collector clear.
	input wire logic clk,
	input wire logic clear,
	// Burst beat from the block.
	input wire logic valid,
	input wire logic first,
	input wire logic last,
	input wire logic [31:0] wdata,
	// Bus clock, enable and reset.
	output logic master_clock,
	output logic master_clock_enable,
	output logic master_bus_reset_n
);
	logic [31:0] beats [0:7];
	int nbeats, first_at, last_at;
	logic pv;
	logic [31:0] pw;
	// The bus clock runs free at 400 ns.
	initial begin
		master_clock = 1'h0;
		forever #200 master_clock = ~master_clock;
	end
	// Enable stays high; reset is released after a while.
	initial begin
		master_clock_enable = 1'h1;
		master_bus_reset_n = 1'h0;
		#1000 master_bus_reset_n = 1'h1;
	end
	// A new beat is a valid word that differs from the one before.
	always @(posedge clk) begin
		if (clear) begin
			nbeats <= 0;
			pv <= 1'h0;
			first_at <= -1;
			last_at <= -1;
		end else begin
			pv <= valid;
			pw <= wdata;
			if (valid && (!pv || wdata != pw) && nbeats < 8) begin
				beats[nbeats] <= wdata;
				nbeats <= nbeats + 1;
				if (first) first_at <= nbeats;
				if (last) last_at <= nbeats;
			end
		end
	end
endmodule
`default_nettype wire

// ==== tb/l2_dirty_sync_master_port_test.sv ====
/*
 Bench for the dirty-state, eviction and sync block.
 Assumes the checker and the far-end model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module l2_dirty_sync_master_port_test;
	logic clk, reset_n, cache_enable, dirty_req, dirty_write, dirty_value;
	logic [3:0] way_count;
	logic [2:0] way_size_sel, ram_latency, dirty_way;
	logic [12:0] dirty_index;
	logic [1:0] dirty_half_mask, linefill_start, linefill_done;
	logic evict_push, sync_req, maint_req, write_buffer_empty;
	logic write_alloc_empty, sync_mode_select, clear;
	logic [31:0] evict_word;
	wire logic dirty_ready_reg, dirty_rvalid_reg, evict_ready_reg;
	wire logic [15:0] dirty_rdata_reg;
	wire logic [1:0] linefill_busy_reg;
	wire logic sync_busy_reg, sync_done_reg, maint_go_reg;
	wire logic master_clock, master_clock_enable, master_bus_reset_n;
	wire logic master_port_0_valid_reg, master_port_0_first_reg;
	wire logic master_port_0_last_reg;
	wire logic [31:0] master_port_0_wdata_reg;
	int miscompares, checks, cycles;
	l2_dirty_sync_master_port dut (.clk, .reset_n, .cache_enable,
		.way_count, .way_size_sel, .ram_latency, .dirty_req, .dirty_write,
		.dirty_index, .dirty_way, .dirty_half_mask, .dirty_value,
		.dirty_ready_reg, .dirty_rvalid_reg, .dirty_rdata_reg, .evict_push,
		.evict_word, .evict_ready_reg, .linefill_start, .linefill_done,
		.linefill_busy_reg, .sync_req, .maint_req, .write_buffer_empty,
		.write_alloc_empty, .sync_busy_reg, .sync_done_reg, .maint_go_reg,
		.sync_mode_select, .master_clock, .master_clock_enable,
		.master_bus_reset_n, .master_port_0_valid_reg,
		.master_port_0_first_reg, .master_port_0_last_reg,
		.master_port_0_wdata_reg);
	master_port_far_end far (.clk, .clear, .valid(master_port_0_valid_reg),
		.first(master_port_0_first_reg), .last(master_port_0_last_reg),
		.wdata(master_port_0_wdata_reg), .master_clock,
		.master_clock_enable, .master_bus_reset_n);
	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end
	// Hang guard.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			tally_and_finish;
		end
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish;
		if (miscompares == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// One dirty access; a read checks its timing and word.
	task automatic dirty_op(input logic w, input logic [2:0] way,
		input logic [1:0] m, input logic v, input int n_exp,
		input logic [15:0] exp);
		int n;
		@(posedge clk);
		dirty_req <= 1'h1;
		dirty_write <= w;
		dirty_way <= way;
		dirty_half_mask <= m;
		dirty_value <= v;
		@(negedge clk);
		repeat (50) if (dirty_ready_reg !== 1'h1) @(negedge clk);
		@(posedge clk);
		dirty_req <= 1'h0;
		if (!w) begin
			n = 0;
			do begin
				@(negedge clk);
				n++;
			end while (dirty_rvalid_reg !== 1'h1 && n < 50);
			check(n, n_exp);
			check({16'h0, dirty_rdata_reg}, {16'h0, exp});
		end
	endtask
	task automatic push_words(input int n, input logic [31:0] base);
		for (int k = 0; k < n; k++) begin
			@(posedge clk);
			evict_push <= 1'h1;
			evict_word <= base + k;
			@(negedge clk);
			repeat (50) if (evict_ready_reg !== 1'h1) @(negedge clk);
		end
		@(posedge clk);
		evict_push <= 1'h0;
	endtask
	// Waits for n beats at the far end and checks them in order.
	task automatic expect_burst(input int n, input logic [31:0] base);
		repeat (2000) if (far.nbeats != n) @(negedge clk);
		for (int k = 0; k < n; k++) check(far.beats[k], base + k);
		check(far.first_at, 0);
		check(far.last_at, n - 1);
	endtask
	task automatic pulse_sync(input logic maint);
		@(posedge clk);
		sync_req <= !maint;
		maint_req <= maint;
		@(posedge clk);
		sync_req <= 1'h0;
		maint_req <= 1'h0;
	endtask
	task automatic test_dirty;
		for (int w = 0; w < 8; w++) dirty_op(1, w, 2'h3, 0, 0, 0);
		dirty_op(1, 3'h7, 2'h3, 1'h1, 0, 0);
		dirty_op(0, 0, 0, 0, 9, 16'hC000);
		@(posedge clk);
		ram_latency <= 3'h0;
		dirty_op(1, 3'h0, 2'h1, 1'h1, 0, 0);
		dirty_op(0, 0, 0, 0, 2, 16'hC001);
		dirty_op(1, 3'h7, 2'h2, 1'h0, 0, 0);
		dirty_op(0, 0, 0, 0, 2, 16'h4001);
		@(posedge clk);
		way_count <= 4'h1;
		dirty_op(0, 0, 0, 0, 2, 16'h0001);
		@(posedge clk);
		way_count <= 4'h8;
	endtask
	// Clears every way, then enables; the way count is then held.
	task automatic test_enable;
		for (int w = 0; w < 8; w++) dirty_op(1, w, 2'h3, 0, 0, 0);
		@(posedge clk);
		cache_enable <= 1'h1;
		way_count <= 4'h1;
		dirty_op(1, 3'h7, 2'h3, 1'h1, 0, 0);
		dirty_op(0, 0, 0, 0, 2, 16'hC000);
	endtask
	// Sync waits on the write buffer but not on a linefill.
	task automatic test_sync;
		logic seen;
		@(posedge clk);
		write_buffer_empty <= 1'h0;
		write_alloc_empty <= 1'h0;
		linefill_start <= 2'h1;
		@(posedge clk);
		linefill_start <= 2'h0;
		pulse_sync(0);
		seen = 1'h0;
		repeat (6) @(negedge clk) seen |= sync_done_reg;
		check(seen, 0);
		check(linefill_busy_reg, 2'h1);
		dirty_op(0, 0, 0, 0, 2, 16'h4001);
		@(posedge clk);
		write_buffer_empty <= 1'h1;
		seen = 1'h0;
		repeat (6) @(negedge clk) seen |= sync_done_reg;
		check(seen, 0);
		@(posedge clk);
		write_alloc_empty <= 1'h1;
		repeat (10) if (sync_done_reg !== 1'h1) @(negedge clk);
		check(sync_done_reg, 1);
		pulse_sync(1);
		repeat (40) if (sync_done_reg !== 1'h1) @(negedge clk);
		check(maint_go_reg, 1);
		@(posedge clk);
		linefill_done <= 2'h1;
		linefill_start <= 2'h2;
		@(posedge clk);
		linefill_done <= 2'h0;
		linefill_start <= 2'h0;
		@(negedge clk);
		check(linefill_busy_reg, 2'h2);
		@(posedge clk);
		linefill_done <= 2'h2;
		@(posedge clk);
		linefill_done <= 2'h0;
		@(negedge clk);
		check(linefill_busy_reg, 2'h0);
	endtask
	task automatic clear_far;
		@(posedge clk);
		clear <= 1'h1;
		@(posedge clk);
		clear <= 1'h0;
	endtask
	initial begin
		{reset_n, cache_enable, dirty_req, dirty_write, dirty_value} = 0;
		{evict_push, sync_req, maint_req, dirty_way, dirty_half_mask} = 0;
		{linefill_start, linefill_done, evict_word} = 0;
		{write_buffer_empty, write_alloc_empty, sync_mode_select} = 3'h7;
		way_count = 4'h8;
		way_size_sel = 3'h4;
		ram_latency = 3'h7;
		dirty_index = 13'h0ABC;
		clear = 1'h1;
		repeat (5) @(posedge clk);
		check(dirty_ready_reg, 0);
		reset_n <= 1'h1;
		clear <= 1'h0;
		@(posedge clk);
		@(negedge clk);
		check(dirty_ready_reg, 1);
		test_dirty;
		test_sync;
		test_enable;
		clear_far;
		push_words(8, 32'h5A000000);
		expect_burst(8, 32'h5A000000);
		@(posedge clk);
		sync_mode_select <= 1'h0;
		clear_far;
		push_words(4, 32'h3C000000);
		pulse_sync(0);
		expect_burst(4, 32'h3C000000);
		tally_and_finish;
	end
endmodule
bind l2_dirty_sync_master_port l2_dirty_sync_sva chk (.clk, .reset_n,
	.ram_latency, .dirty_req, .dirty_write, .dirty_ready_reg,
	.dirty_rvalid_reg, .sync_req, .maint_req, .write_buffer_empty,
	.write_alloc_empty, .sync_busy_reg, .sync_done_reg, .maint_go_reg,
	.evict_ready_reg, .sync_mode_select, .master_port_0_valid_reg,
	.master_port_0_first_reg, .master_port_0_last_reg);
`default_nettype wire
